// *** shared/t1as_pkg.sv ***
// Package: offsets, fields and timing of the T1 alarm and status registers
`default_nettype none
package t1as_pkg;
    // ************************************************************
    // Register offsets and index codes
    // ************************************************************
    localparam logic [7:0] ADDR_INFO3 = 8'h10;
    localparam logic [7:0] ADDR_STAT1 = 8'h20;
    localparam logic [7:0] ADDR_INFO2 = 8'h31;
    localparam logic [1:0] IDX_INFO3  = 2'h0;
    localparam logic [1:0] IDX_STAT1  = 2'h1;
    localparam logic [1:0] IDX_INFO2  = 2'h2;
    localparam logic [1:0] IDX_NONE   = 2'h3;
    localparam logic [7:0] RESET_VAL  = 8'h00;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_LEVEL_LSB  = 6;
    localparam int BIT_JITTER     = 5;
    localparam int BIT_RXCLK_LOSS = 4;
    localparam int BIT_FRM_LOSS   = 3;
    localparam int BIT_ALARM_TOP  = 3;
    localparam logic [7:0] INFO3_LIVE  = 8'hC0;
    localparam logic [7:0] INFO3_UNDEF = 8'h07;
    // ************************************************************
    // Timing and detector counts
    // ************************************************************
    localparam int MCLK_NS        = 50;
    localparam int RXCLK_LOSS_NS  = 2000;
    localparam int TXCLK_LOSS_NS  = 5200;
    localparam int RXCLK_LOSS_CYC = (RXCLK_LOSS_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int TXCLK_LOSS_CYC = (TXCLK_LOSS_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int BLUE_WIN_NS    = 3000000;
    localparam int BLUE_WIN_CYC   = BLUE_WIN_NS / MCLK_NS;
    localparam int BLUE_SET_MAX   = 5;
    localparam int RED_ZEROS      = 192;
    localparam int RED_ONES       = 14;
    localparam int RED_WIN        = 112;
    localparam int DENS_ZEROS     = 16;
    localparam int YEL_CHANS      = 256;
    localparam int YEL_MIN        = 254;
    localparam int ESF_RUN        = 16;
    localparam int ESF_CLR_MAX    = 14;
    localparam int JA_MARGIN      = 4;
endpackage
`default_nettype wire

// *** core/t1as_status.sv ***
// Alarm detectors and latched status registers of the T1 receive and transmit sides
`default_nettype none
// Contract
// - Framer reaching sync sets sync-regained flag, held until read.
// - Line carrier loss ending sets carrier-restored flag, held until read.
// - Transmit store overfill sets full flag; underflow sets empty flag.
// - Any transmit store slip, either direction, sets transmit-slip flag.
// - Blue alarm clearing sets blue-cleared flag, held until read.
// - Receive and transmit streams each flag pulse-density violations.
// - Two-bit field reports receive level in four bands.
// - Jitter FIFO within four bits of its limit sets limit-trip flag.
// - Receive clock still for 2 us sets clock-loss flag, within 4 us.
// - 192 zeros set framer carrier loss; 14 ones in 112 clear it.
// - Low three bits of info three always read zero; host ignores.
// - Loop-up and loop-down flags follow reception of programmed codes.
// - Transmit clock still 5.2 us flags loss, drives pin, falls back.
// - Any receive store slip sets receive-slip flag.
// - Blue set at five or fewer zeros per 3 ms, cleared at six.
// - Bit-2 mode: 254 of 256 channel zeros set yellow, fewer clear.
// - Twelfth F-bit mode: two ones set yellow, two zeros clear.
// - ESF: 16 consecutive 00FF set yellow; 14 or fewer of 16 clear.
// - 192 zeros set red; 14 ones in 112 from first one clear.
// - Loss-of-sync bit set while framer is out of sync.
// - Yellow bit set while yellow alarm is detected.
// - Bits latch until read; alarm bits stay set while alarm persists.
// - Written mask picks bits refreshed in the read copy; others hold.
// - Unmasked alarm change or status-one event pulls interrupt low until read.
module t1as_status #(
    parameter logic [15:0] BLUE_WIN_CYC = 16'(t1as_pkg::BLUE_WIN_CYC)
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata_q,
    output logic            int_n_q,
    input  wire logic [7:0] int_mask,
    input  wire logic       rx_clock_input,
    input  wire logic       tx_clock_input,
    input  wire logic       rx_positive_data,
    input  wire logic       rx_negative_data,
    input  wire logic       line_rx_tip,
    input  wire logic       line_rx_ring,
    input  wire logic       tx_data_bit,
    input  wire logic       framer_in_sync,
    input  wire logic       rx_store_slip,
    input  wire logic       tx_store_full,
    input  wire logic       tx_store_empty,
    input  wire logic       loop_up_match,
    input  wire logic       loop_down_match,
    input  wire logic [7:0] ja_fill,
    input  wire logic [7:0] ja_limit,
    input  wire logic [1:0] rx_level,
    input  wire logic       esf_mode,
    input  wire logic       yellow_mode_select,
    input  wire logic       bit2_strobe,
    input  wire logic       bit2_value,
    input  wire logic       fbit12_strobe,
    input  wire logic       fbit12_value,
    input  wire logic       dl_strobe,
    input  wire logic       dl_match,
    input  wire logic       loss_pin_select,
    input  wire logic       tx_clock_fallback_enable,
    output logic            loss_pin_q,
    output logic            tx_clk_from_rx_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    function automatic logic [1:0] reg_idx(input logic [7:0] a);
        case (a)
            t1as_pkg::ADDR_INFO3: reg_idx = t1as_pkg::IDX_INFO3;
            t1as_pkg::ADDR_STAT1: reg_idx = t1as_pkg::IDX_STAT1;
            t1as_pkg::ADDR_INFO2: reg_idx = t1as_pkg::IDX_INFO2;
            default:              reg_idx = t1as_pkg::IDX_NONE;
        endcase
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [6:0] pin_raw;
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic [1:0] clk_last_q;
    assign pin_raw = {tx_data_bit, line_rx_ring, line_rx_tip, rx_negative_data,
                      rx_positive_data, tx_clock_input, rx_clock_input};
    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1_q    <= 7'h00;
            sync2_q    <= 7'h00;
            clk_last_q <= 2'h0;
        end else begin
            sync1_q    <= pin_raw;
            sync2_q    <= sync1_q;
            clk_last_q <= sync2_q[1:0];
        end
    end
    logic rx_strobe;
    logic tx_strobe;
    logic [1:0] clk_edge;
    logic [1:0] line_bit;
    assign clk_edge  = sync2_q[1:0] ^ clk_last_q;
    assign rx_strobe = sync2_q[0] & ~clk_last_q[0];
    assign tx_strobe = sync2_q[1] & ~clk_last_q[1];
    assign line_bit  = {sync2_q[4] | sync2_q[5], sync2_q[2] | sync2_q[3]};

    // ************************************************************
    // Clock-loss counters, [0] receive, [1] transmit
    // ************************************************************
    logic [7:0] idle_q [2];
    logic [1:0] clk_loss;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cl
            localparam logic [7:0] LIM = (g == 0) ? 8'(t1as_pkg::RXCLK_LOSS_CYC)
                                                  : 8'(t1as_pkg::TXCLK_LOSS_CYC);
            always_ff @(posedge mclk) begin
                if (reset || clk_edge[g]) begin
                    idle_q[g] <= 8'h00;
                end else if (idle_q[g] != LIM) begin
                    idle_q[g] <= idle_q[g] + 8'h01;
                end
            end
            assign clk_loss[g] = (idle_q[g] == LIM);
        end
    endgenerate

    // ************************************************************
    // Carrier-loss detectors, [0] framer data, [1] line
    // ************************************************************
    logic [7:0] zrun_q [2];
    logic [6:0] win_q  [2];
    logic [3:0] ones_q [2];
    logic [1:0] inwin_q;
    logic [1:0] red_q;
    generate
        for (g = 0; g < 2; g++) begin : g_cd
            logic [4:0] ones_n;
            assign ones_n = {1'b0, ones_q[g]} + {4'h0, line_bit[g]};
            always_ff @(posedge mclk) begin
                if (reset) begin
                    zrun_q[g]  <= 8'h00;
                    win_q[g]   <= 7'h00;
                    ones_q[g]  <= 4'h0;
                    inwin_q[g] <= 1'b0;
                    red_q[g]   <= 1'b0;
                end else if (rx_strobe) begin
                    if (line_bit[g]) begin
                        zrun_q[g] <= 8'h00;
                    end else if (zrun_q[g] != 8'(t1as_pkg::RED_ZEROS)) begin
                        zrun_q[g] <= zrun_q[g] + 8'h01;
                    end
                    if (!red_q[g]) begin
                        if (!line_bit[g] && zrun_q[g] == 8'(t1as_pkg::RED_ZEROS - 1)) begin
                            red_q[g]   <= 1'b1;
                            inwin_q[g] <= 1'b0;
                        end
                    end else if (!inwin_q[g]) begin
                        if (line_bit[g]) begin
                            inwin_q[g] <= 1'b1;
                            win_q[g]   <= 7'h01;
                            ones_q[g]  <= 4'h1;
                        end
                    end else begin
                        win_q[g]  <= win_q[g] + 7'h01;
                        ones_q[g] <= ones_n[3:0];
                        if (ones_n >= 5'(t1as_pkg::RED_ONES)) begin
                            red_q[g]   <= 1'b0;
                            inwin_q[g] <= 1'b0;
                        end else if (win_q[g] == 7'(t1as_pkg::RED_WIN - 1)) begin
                            inwin_q[g] <= 1'b0;
                        end
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Pulse density, receive from framer data and transmit data
    // ************************************************************
    logic [3:0] tzrun_q;
    logic       rx_pdv;
    logic       tx_pdv;
    always_ff @(posedge mclk) begin
        if (reset) begin
            tzrun_q <= 4'h0;
        end else if (tx_strobe) begin
            tzrun_q <= sync2_q[6] ? 4'h0 : (tzrun_q == 4'hF ? 4'hF : tzrun_q + 4'h1);
        end
    end
    assign rx_pdv = rx_strobe & ~line_bit[0] & (zrun_q[0] == 8'(t1as_pkg::DENS_ZEROS - 1));
    assign tx_pdv = tx_strobe & ~sync2_q[6] & (tzrun_q == 4'(t1as_pkg::DENS_ZEROS - 1));

    // ************************************************************
    // Blue alarm over a fixed window
    // ************************************************************
    logic [15:0] btmr_q;
    logic [2:0]  bzero_q;
    logic [2:0]  bzero_n;
    logic        blue_q;
    assign bzero_n = (rx_strobe && !line_bit[0] && bzero_q != 3'h6) ? bzero_q + 3'h1 : bzero_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            btmr_q  <= 16'h0000;
            bzero_q <= 3'h0;
            blue_q  <= 1'b0;
        end else if (btmr_q == BLUE_WIN_CYC - 16'h0001) begin
            btmr_q  <= 16'h0000;
            bzero_q <= 3'h0;
            blue_q  <= (bzero_n <= 3'(t1as_pkg::BLUE_SET_MAX));
        end else begin
            btmr_q  <= btmr_q + 16'h0001;
            bzero_q <= bzero_n;
        end
    end

    // ************************************************************
    // Yellow alarm in three modes
    // ************************************************************
    logic [7:0] ych_q;
    logic [8:0] yzero_q;
    logic [8:0] yzero_n;
    logic       f12_last_q;
    logic [4:0] drun_q;
    logic [3:0] dwin_q;
    logic [4:0] dhit_q;
    logic [4:0] dhit_n;
    logic       yel_q;
    assign yzero_n = yzero_q + {8'h00, ~bit2_value};
    assign dhit_n  = dhit_q + {4'h0, dl_match};
    always_ff @(posedge mclk) begin
        if (reset) begin
            ych_q      <= 8'h00;
            yzero_q    <= 9'h000;
            f12_last_q <= 1'b0;
            drun_q     <= 5'h00;
            dwin_q     <= 4'h0;
            dhit_q     <= 5'h00;
            yel_q      <= 1'b0;
        end else if (esf_mode) begin
            if (dl_strobe) begin
                drun_q <= !dl_match ? 5'h00 : (drun_q == 5'h10 ? drun_q : drun_q + 5'h01);
                dwin_q <= dwin_q + 4'h1;
                dhit_q <= (dwin_q == 4'hF) ? 5'h00 : dhit_n;
                if (!yel_q && dl_match && drun_q == 5'(t1as_pkg::ESF_RUN - 1)) begin
                    yel_q  <= 1'b1;
                    dwin_q <= 4'h0;
                    dhit_q <= 5'h00;
                end else if (yel_q && dwin_q == 4'hF && dhit_n <= 5'(t1as_pkg::ESF_CLR_MAX)) begin
                    yel_q <= 1'b0;
                end
            end
        end else if (yellow_mode_select) begin
            if (fbit12_strobe) begin
                f12_last_q <= fbit12_value;
                if (f12_last_q == fbit12_value) begin
                    yel_q <= fbit12_value;
                end
            end
        end else if (bit2_strobe) begin
            ych_q   <= ych_q + 8'h01;
            yzero_q <= (ych_q == 8'(t1as_pkg::YEL_CHANS - 1)) ? 9'h000 : yzero_n;
            if (ych_q == 8'(t1as_pkg::YEL_CHANS - 1)) begin
                yel_q <= (yzero_n >= 9'(t1as_pkg::YEL_MIN));
            end
        end
    end

    // ************************************************************
    // Event collection and edge detection
    // ************************************************************
    logic       insync_last_q;
    logic       red_last_q;
    logic       blue_last_q;
    logic [3:0] alm_last_q;
    logic [3:0] alm_now;
    logic       jitter_limit_trip;
    logic [7:0] ev [3];
    logic [7:0] live [3];
    always_ff @(posedge mclk) begin
        if (reset) begin
            // Seeded as in sync so a framer already locked at release gives no false regain event
            insync_last_q <= 1'b1;
            red_last_q    <= 1'b0;
            blue_last_q   <= 1'b0;
            alm_last_q    <= 4'h0;
        end else begin
            insync_last_q <= framer_in_sync;
            red_last_q    <= red_q[1];
            blue_last_q   <= blue_q;
            alm_last_q    <= alm_now;
        end
    end
    assign alm_now = {blue_q, yel_q, red_q[1], ~framer_in_sync};
    assign jitter_limit_trip    = ({1'b0, ja_fill} + 9'(t1as_pkg::JA_MARGIN)) >= {1'b0, ja_limit};
    assign ev[t1as_pkg::IDX_STAT1] = {loop_up_match, loop_down_match, clk_loss[1], rx_store_slip, alm_now};
    assign ev[t1as_pkg::IDX_INFO2] = {framer_in_sync & ~insync_last_q,
                                      red_last_q & ~red_q[1],
                                      tx_store_full, tx_store_empty,
                                      tx_store_full | tx_store_empty,
                                      blue_last_q & ~blue_q,
                                      rx_pdv, tx_pdv};
    assign ev[t1as_pkg::IDX_INFO3] = {2'h0, jitter_limit_trip, clk_loss[0], red_q[0], 3'h0};
    assign live[t1as_pkg::IDX_INFO3] = {rx_level, 6'h00};
    assign live[t1as_pkg::IDX_STAT1] = 8'h00;
    assign live[t1as_pkg::IDX_INFO2] = 8'h00;

    // ************************************************************
    // Latches, read copies and host access
    // ************************************************************
    // Clear acts on the read copy, so an event landing after the mask
    // write survives the read and is seen on the next poll.
    logic [7:0] lat_q  [3];
    logic [7:0] shown_q [3];
    logic [7:0] src    [3];
    logic [7:0] clr    [3];
    logic [1:0] wi;
    logic [1:0] ri;
    assign wi = wr_en ? reg_idx(addr) : t1as_pkg::IDX_NONE;
    assign ri = rd_en ? reg_idx(addr) : t1as_pkg::IDX_NONE;
    generate
        for (g = 0; g < 3; g++) begin : g_reg
            assign src[g] = (g == 0) ? ((lat_q[g] & ~t1as_pkg::INFO3_LIVE & ~t1as_pkg::INFO3_UNDEF) | live[g])
                                     : lat_q[g];
            assign clr[g] = (ri == 2'(g)) ? shown_q[g] : 8'h00;
            always_ff @(posedge mclk) begin
                if (reset) begin
                    lat_q[g]   <= t1as_pkg::RESET_VAL;
                    shown_q[g] <= t1as_pkg::RESET_VAL;
                end else begin
                    lat_q[g] <= (lat_q[g] & ~clr[g]) | ev[g];
                    if (wi == 2'(g)) begin
                        shown_q[g] <= (wdata & src[g]) | (~wdata & shown_q[g]);
                    end
                end
            end
        end
    endgenerate
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_q <= t1as_pkg::RESET_VAL;
        end else if (rd_en) begin
            rdata_q <= (ri == t1as_pkg::IDX_NONE) ? 8'h00 : shown_q[ri];
        end
    end

    // ************************************************************
    // Interrupt and loss pin
    // ************************************************************
    logic [7:0] irq_q;
    logic [7:0] irq_set;
    assign irq_set = {ev[t1as_pkg::IDX_STAT1][7:4], alm_now ^ alm_last_q};
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_q            <= 8'h00;
            int_n_q          <= 1'b1;
            loss_pin_q       <= 1'b0;
            tx_clk_from_rx_q <= 1'b0;
        end else begin
            irq_q            <= (irq_q & ~clr[t1as_pkg::IDX_STAT1]) | irq_set;
            int_n_q          <= ~|(irq_q & int_mask);
            loss_pin_q       <= loss_pin_select ? clk_loss[1] : ~framer_in_sync;
            tx_clk_from_rx_q <= tx_clock_fallback_enable & clk_loss[1];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_red_trip;
        rx_strobe && !line_bit[1] && !red_q[1] && zrun_q[1] == 8'(t1as_pkg::RED_ZEROS - 1);
    endsequence
    sequence s_read_stat1;
        rd_en && addr == t1as_pkg::ADDR_STAT1;
    endsequence
    a_latch_holds: assert property (lat_q[2][7] && clr[2][7] == 1'b0 |=> lat_q[2][7])
        else $error("latched flag lost without read");
    a_read_copy: assert property (s_read_stat1 |=> rdata_q == $past(shown_q[1]))
        else $error("read data differs from read copy");
    a_mask_hold: assert property (wr_en && addr == t1as_pkg::ADDR_INFO2 && !wdata[0]
        |=> shown_q[2][0] == $past(shown_q[2][0]))
        else $error("masked-out bit changed");
    a_red_trip: assert property (s_red_trip |=> red_q[1] ##1 lat_q[1][1])
        else $error("red alarm not raised after zero run");
    a_tx_loss_pin: assert property (clk_loss[1] && loss_pin_select |=> loss_pin_q)
        else $error("loss pin not driven");
    a_clk_restart: assert property (clk_edge[0] |=> !clk_loss[0] [*2])
        else $error("clock loss flagged right after edge");
    a_int_low: assert property (|(irq_q & int_mask) |=> !int_n_q)
        else $error("interrupt not asserted");
    a_undef_low: assert property (rd_en && addr == t1as_pkg::ADDR_INFO3 |=> rdata_q[2:0] == 3'h0)
        else $error("unassigned bits not zero");
    a_sync_lost: assert property (!framer_in_sync |=> lat_q[1][0])
        else $error("loss of sync not latched");
    a_jitter_trip: assert property (jitter_limit_trip |=> lat_q[0][t1as_pkg::BIT_JITTER])
        else $error("jitter trip not latched");
endmodule
`default_nettype wire

// *** testbench/t1as_host.sv ***
// Host processor model on the status register port
`default_nettype none
module t1as_host (
    input  wire logic       mclk,
    output logic      [7:0] addr,
    output logic            wr_en,
    output logic            rd_en,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata_q
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {addr, wr_en, rd_en, wdata} = 18'h0_0000;
    // Write-back of the AND keeps an event that lands mid-read latched
    task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] v);
        @(posedge mclk) #1;
        {addr, wdata, wr_en} = {a, m, 1'b1};
        @(posedge mclk) #1;
        {wr_en, rd_en} = 2'h1;
        @(posedge mclk) #1;
        rd_en = 1'b0;
        v = rdata_q & m & ((a == t1as_pkg::ADDR_INFO3) ? 8'hF8 : 8'hFF);
        {wdata, wr_en} = {v, 1'b1};
        @(posedge mclk) #1;
        {wdata, wr_en} = {~v, 1'b0};
    endtask
endmodule
`default_nettype wire

// *** testbench/t1as_status_tb.sv ***
// Self-checking bench for the T1 alarm and status registers
`default_nettype none
module t1as_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] st1 = t1as_pkg::ADDR_STAT1, in2 = t1as_pkg::ADDR_INFO2, in3 = t1as_pkg::ADDR_INFO3;
    localparam int         yn[7] = '{256, 3, 253, 2, 2, 16, 16};
    logic       mclk, reset, rc, tc, rc_run, tc_run, rxd, txd, sync, rx_slip_flag, tfull, tempty, loop_up_seen, loop_down_seen, esf;
    logic       ysel, b2s, b2v, f12s, f12v, dls, dlm, lsel, fben, wr_en, rd_en, int_n_q, lpin, txfb;
    logic [7:0] addr, wdata, rdata_q, ja_fill, ja_limit, v;
    logic [1:0] lvl;
    int         n_fail, n_tests, seed, cyc;
    t1as_status #(.BLUE_WIN_CYC(16'h00C8)) u_t1as_status (
        .mclk, .reset, .addr, .wr_en, .rd_en, .wdata, .rdata_q, .int_n_q, .int_mask(8'h10),
        .rx_clock_input(rc), .tx_clock_input(tc), .rx_positive_data(rxd), .rx_negative_data(rxd),
        .line_rx_tip(rxd), .line_rx_ring(rxd), .tx_data_bit(txd), .framer_in_sync(sync),
        .rx_store_slip(rx_slip_flag), .tx_store_full(tfull), .tx_store_empty(tempty), .loop_up_match(loop_up_seen),
        .loop_down_match(loop_down_seen), .ja_fill, .ja_limit, .rx_level(lvl), .esf_mode(esf),
        .yellow_mode_select(ysel), .bit2_strobe(b2s), .bit2_value(b2v), .fbit12_strobe(f12s),
        .fbit12_value(f12v), .dl_strobe(dls), .dl_match(dlm), .loss_pin_select(lsel),
        .tx_clock_fallback_enable(fben), .loss_pin_q(lpin), .tx_clk_from_rx_q(txfb));
    t1as_host u_t1as_host (.mclk, .addr, .wr_en, .rd_en, .wdata, .rdata_q);
    initial forever #25 mclk = ~mclk;
    // 130 ns half period keeps line clock edges off the rising mclk edges
    always #130 begin
        if (rc_run) rc = ~rc;
        if (tc_run) tc = ~tc;
    end
    always @(posedge mclk) if (++cyc == 20000) begin
        n_fail++;
        print_verdict();
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Optional full poll first, so a level flag shows only if still present
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp, input bit fl);
        if (fl) u_t1as_host.poll(a, 8'hFF, v);
        u_t1as_host.poll(a, m, v);
        check(v, exp);
    endtask
    task automatic pulse(input int k, input logic b, input int n);
        repeat (n) begin
            wt(1);
            {rx_slip_flag, tfull, tempty, b2s, f12s, dls, b2v, f12v, dlm} = {6'h20 >> k, {3{b}}};
            wt(1);
            {rx_slip_flag, tfull, tempty, b2s, f12s, dls} = 6'h00;
        end
        wt(3);
    endtask
    task automatic bits(input int n, input logic b);
        repeat (n) begin
            @(posedge rc);
            {rxd, txd} = {2{b}};
        end
        @(posedge rc);
        {rxd, txd} = 2'h3;
        wt(2);
    endtask
    function automatic logic [7:0] info3_exp(input logic [1:0] l, input logic [7:0] f, input logic [7:0] lim);
        return {l, ({1'b0, f} + 9'h004 >= {1'b0, lim}), 5'h00};
    endfunction
    task automatic print_verdict();
        $display("Checks made %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        seed = 4368;
        {mclk, reset, rc, tc, rc_run, tc_run, rxd, txd, sync} = 9'h09F;
        {rx_slip_flag, tfull, tempty, loop_up_seen, loop_down_seen, esf, ysel, b2s, b2v, f12s, f12v, dls, dlm, lsel, fben} = 15'h0000;
        {ja_fill, ja_limit, lvl} = 18'h0_0000;
        wt(8);
        reset = 1'b0;
        check({7'h00, int_n_q}, 8'h01);
        rd(in2, 8'h80, 8'h00, 1'b0);
        pulse(0, 1'b0, 1);
        check({7'h00, int_n_q}, 8'h00);
        rd(st1, 8'h10, 8'h10, 1'b0);
        wt(2);
        check({7'h00, int_n_q}, 8'h01);
        rd(st1, 8'h10, 8'h00, 1'b0);
        pulse(1, 1'b0, 1);
        rd(in2, 8'h38, 8'h28, 1'b0);
        pulse(2, 1'b0, 1);
        rd(in2, 8'h38, 8'h18, 1'b0);
        for (int i = 0; i < 8; i++) begin
            lvl = 2'(i);
            ja_limit = 8'($random(seed)) | 8'h10;
            ja_fill = (i < 2) ? ja_limit - 8'(4 + i) : 8'($random(seed)) & 8'h7F;
            rd(in3, 8'hE0, info3_exp(lvl, ja_fill, ja_limit), 1'b1);
        end
        for (int j = 2; j >= 0; j--) begin
            {loop_up_seen, loop_down_seen} = 2'(j);
            rd(st1, 8'hC0, {2'(j), 6'h00}, 1'b1);
        end
        sync = 1'b0;
        rd(in2, 8'h80, 8'h00, 1'b1);
        rd(st1, 8'h01, 8'h01, 1'b1);
        check({7'h00, lpin}, 8'h01);
        sync = 1'b1;
        wt(3);
        rd(in2, 8'h80, 8'h80, 1'b0);
        rd(st1, 8'h01, 8'h00, 1'b1);
        bits(60, 1'b1);
        bits(191, 1'b0);
        rd(st1, 8'h02, 8'h00, 1'b1);
        bits(192, 1'b0);
        rd(st1, 8'h0A, 8'h02, 1'b1);
        rd(in3, 8'h08, 8'h08, 1'b0);
        rd(in2, 8'h07, 8'h07, 1'b0);
        bits(120, 1'b1);
        rd(st1, 8'h0A, 8'h08, 1'b1);
        rd(in2, 8'h40, 8'h40, 1'b0);
        rd(in3, 8'h08, 8'h00, 1'b1);
        for (int i = 0; i < 7; i++) begin
            {ysel, esf} = {i > 2, i > 4};
            pulse(3 + int'(i > 2) + int'(i > 4), i[0], yn[i]);
            rd(st1, 8'h04, {5'h00, (i < 2) || i[0], 2'h0}, 1'b1);
        end
        {lsel, fben, rc_run} = 3'h6;
        wt(16);
        rd(in3, 8'h10, 8'h00, 1'b1);
        wt(30);
        rd(in3, 8'h10, 8'h10, 1'b1);
        tc_run = 1'b0;
        wt(95);
        check({6'h00, lpin, txfb}, 8'h00);
        wt(20);
        check({6'h00, lpin, txfb}, 8'h03);
        rd(st1, 8'h20, 8'h20, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
